// ---- verification/i2c_eeprom_slave_write_port_sva.sv ----
// Checker of the EEPROM write port: bus answers and the programming cycle.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
module i2c_eeprom_slave_write_port_sva #(
  parameter int WRITE_CYCLES = eeprom_wr_pkg::WR_CYCLES
) (
  // Clocks and reset
  input wire logic                              clk,
  input wire logic                              rst,
  input wire logic                              linkClk,
  // Bus and status
  input wire logic                              sclIn,
  input wire logic                              sdaIn,
  input wire logic                              sdaOut,
  input wire logic                              sdaOeN,
  input wire logic                              resetActive,
  input wire logic                              memWrEn,
  input wire logic [eeprom_wr_pkg::ADDR_W-1:0]  memWrAddr,
  input wire logic                              busy
);
  // ----
  // Helpers
  // ----
  logic startSeen;
  logic prevSda;
  int   busyCnt;
  // Seen on raw pins, so earlier than the synchronised view of the design
  always_ff @(posedge linkClk) begin
    prevSda <= sdaIn;
    if (rst)
      startSeen <= 1'b0;
    else if (sclIn && prevSda && !sdaIn)
      startSeen <= 1'b1;
  end
  always_ff @(posedge clk) begin
    if (rst || !busy)
      busyCnt <= 0;
    else
      busyCnt <= busyCnt + 1;
  end
  no_start_quiet_a: assert property (@(posedge linkClk) disable iff (rst)
    !startSeen |-> sdaOeN) else $error("drive before any start");
  open_drain_a: assert property (@(posedge linkClk) disable iff (rst)
    !sdaOeN |-> sdaOut == 1'b0) else $error("data pin driven high");
  ack_on_low_a: assert property (@(posedge linkClk) disable iff (rst)
    $fell(sdaOeN) |-> !sclIn) else $error("drive began with clock high");
  ack_hold_a: assert property (@(posedge linkClk) disable iff (rst)
    $fell(sdaOeN) |-> !sdaOeN [*8]) else $error("acknowledge too short");
  stable_high_a: assert property (@(posedge linkClk) disable iff (rst)
    sclIn [*4] |-> $stable(sdaOeN)) else $error("data changed with clock high");
  supervisor_mute_a: assert property (@(posedge linkClk) disable iff (rst)
    resetActive [*6] |-> sdaOeN) else $error("answer during supervisor reset");
  busy_mute_a: assert property (@(posedge clk) disable iff (rst)
    busy |-> sdaOeN) else $error("answer while programming");
  cycle_len_a: assert property (@(posedge clk) disable iff (rst)
    busy |-> busyCnt < WRITE_CYCLES) else $error("programming cycle too long");
  commit_busy_a: assert property (@(posedge clk) disable iff (rst)
    memWrEn |-> busy) else $error("array write outside the cycle");
  commit_order_a: assert property (@(posedge clk) disable iff (rst)
    memWrEn ##1 memWrEn |-> memWrAddr[10:4] == $past(memWrAddr[10:4])
      && memWrAddr[3:0] > $past(memWrAddr[3:0])) else $error("page order broken");
  cover property (@(posedge clk) disable iff (rst) $rose(busy));
  cover property (@(posedge clk) disable iff (rst) memWrEn ##1 memWrEn);
  cover property (@(posedge linkClk) disable iff (rst) $fell(sdaOeN));
endmodule

bind i2c_eeprom_slave_write_port i2c_eeprom_slave_write_port_sva #(
  .WRITE_CYCLES(WRITE_CYCLES)
) i_sva (.clk, .rst, .linkClk, .sclIn, .sdaIn, .sdaOut, .sdaOeN,
  .resetActive, .memWrEn, .memWrAddr, .busy);

// ---- verification/i2c_eeprom_slave_write_port_tb.sv ----
// Self-checking bench of the EEPROM write port with a bus master model.
// Assumes a 25 MHz system clock and a free 8 MHz link clock.
`timescale 1ns/1ps
module i2c_eeprom_slave_write_port_tb;
  import eeprom_wr_pkg::*;
  // ----
  // Set-up
  // ----
  localparam int WC = 2000;
  logic clk = 1'b0, linkClk = 1'b0, rst = 1'b1, ce = 1'b1;
  logic wp = 1'b0, resetActive = 1'b0;
  logic scl, mLow, sdaOut, sdaOeN, memWrEn, rdStrobe, busy;
  logic [ADDR_W-1:0] memWrAddr;
  logic [BYTE_W-1:0] memWrData, rdData = 8'h5A;
  logic [7:0]        mem [2048];
  int                wrCount = 0, rdCount = 0, bad_count = 0, checks = 0;
  wire sdaWire = !(mLow || (sdaOeN === 1'b0 && sdaOut === 1'b0));
  always #20 clk = ~clk;
  initial #7 forever #62.5 linkClk = ~linkClk;
  // Sampled mid-cycle so a one-cycle pulse is seen once, away from its launch edge
  always @(negedge clk) begin
    if (memWrEn === 1'b1) begin
      mem[memWrAddr] = memWrData;
      wrCount++;
    end
    if (rdStrobe === 1'b1)
      rdCount++;
  end
  i2c_eeprom_slave_write_port #(.WRITE_CYCLES(WC)) i_dut (.clk, .rst, .ce, .linkClk,
    .sclIn(scl), .sdaIn(sdaWire), .sdaOut, .sdaOeN, .wp, .resetActive, .memWrEn,
    .memWrAddr, .memWrData, .rdStrobe, .rdData, .busy);
  i2c_master_model i_master (.scl(scl), .sdaLow(mLow), .sdaWire(sdaWire));
  task automatic stop_test();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input logic ok, input string m);
    checks++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask
  task automatic waitBusy(input logic lvl, input int lim);
    int n = 0;
    while (busy !== lvl && n < lim) begin
      @(negedge clk);
      n++;
    end
    if (busy !== lvl) begin
      check(1'b0, "busy wait timed out");
      stop_test();
    end
  endtask
  task automatic wr(input logic [7:0] d, input logic e, input string m);
    logic [7:0] q;
    logic a;
    i_master.byteIo(d, 1'b0, q, a);
    check(a === e, m);
  endtask
  // ----
  // Scenarios
  // ----
  task automatic byte_write();
    int c0 = wrCount;
    i_master.start();
    wr(8'hAA, 1'b1, "slave byte");
    wr(8'h37, 1'b1, "word address");
    wr(8'hC4, 1'b1, "data byte");
    i_master.stop();
    i_master.start();
    wr(8'hAA, 1'b0, "poll while busy");
    i_master.stop();
    waitBusy(1'b0, WC);
    check(mem[11'h537] === 8'hC4 && wrCount - c0 == 1, "byte write");
    i_master.start();
    wr(8'hAA, 1'b1, "poll after cycle");
    i_master.stop();
  endtask
  task automatic page_wrap();
    int c0 = wrCount;
    int k;
    i_master.start();
    wr(8'hA4, 1'b1, "slave byte");
    wr(8'h1E, 1'b1, "word address");
    for (int i = 0; i < 18; i++) wr(8'(16 + i), 1'b1, "page data");
    i_master.stop();
    waitBusy(1'b1, 50);
    waitBusy(1'b0, WC);
    check(wrCount - c0 == 16, "page write count");
    for (int i = 0; i < 16; i++) begin
      k = (i + 2) % 16;
      if (k < 2)
        k += 16;
      check(mem[{3'h2, 4'h1, 4'(i)}] === 8'(16 + k), "page byte");
    end
  endtask
  // Near misses of the fixed pattern, one bit off at each end
  task automatic bad_addr();
    i_master.start();
    wr(8'hB0, 1'b0, "foreign address");
    wr(8'h00, 1'b0, "ignored byte");
    i_master.start();
    wr(8'h20, 1'b0, "foreign address");
    i_master.stop();
    repeat (20) @(negedge clk);
    check(busy === 1'b0, "no cycle after foreign");
  endtask
  task automatic wp_block();
    int c0 = wrCount;
    @(negedge clk);
    wp = 1'b1;
    i_master.start();
    wr(8'hA0, 1'b1, "slave byte protected");
    wr(8'h05, 1'b1, "word protected");
    wr(8'h99, 1'b0, "data protected");
    wr(8'h77, 1'b0, "second data protected");
    i_master.stop();
    repeat (20) @(negedge clk);
    check(busy === 1'b0 && wrCount == c0, "protected page");
    wp = 1'b0;
  endtask
  task automatic supervisor();
    @(negedge clk);
    resetActive = 1'b1;
    i_master.start();
    wr(8'hA0, 1'b0, "address in reset");
    i_master.stop();
    @(negedge clk);
    resetActive = 1'b0;
  endtask
  task automatic read_back();
    logic [7:0] q;
    logic a;
    int r0 = rdCount;
    i_master.start();
    wr(8'hA1, 1'b1, "read slave byte");
    i_master.byteIo(8'hFF, 1'b1, q, a);
    check(q === 8'h5A, "first read byte");
    i_master.byteIo(8'hFF, 1'b0, q, a);
    check(q === 8'h5A && sdaOeN === 1'b1, "read end");
    i_master.stop();
    // One fetch at the match, one per byte started; the refused byte is fetched too
    check(rdCount - r0 == 3, "read fetch count");
  endtask
  // Reset outlasts four link clocks so the link side is cleared too
  initial begin
    repeat (16) @(negedge clk);
    rst = 1'b0;
    repeat (20) @(negedge clk);
    byte_write();
    page_wrap();
    bad_addr();
    wp_block();
    supervisor();
    read_back();
    stop_test();
  end
endmodule

// ---- verification/i2c_master_model.sv ----
// Two-wire bus master model: clock, start, stop and byte transfers.
// Assumes SDA is resolved outside with a pull-up; SCL is driven only here.
`timescale 1ns/1ps
module i2c_master_model (
  // Bus
  output logic      scl,
  output logic      sdaLow,
  input  wire logic sdaWire
);
  // ----
  // Bus cycles
  // ----
  localparam int Q = 500;
  // Clock rests high between frames
  initial begin
    scl = 1'b1;
    sdaLow = 1'b0;
  end
  task automatic start();
    #Q sdaLow = 1'b0;
    #Q scl = 1'b1;
    #Q sdaLow = 1'b1;
    #Q scl = 1'b0;
  endtask
  task automatic stop();
    #Q sdaLow = 1'b1;
    #Q scl = 1'b1;
    #Q sdaLow = 1'b0;
    #Q;
  endtask
  // Data moves only with the clock low; long low phase covers sync delay
  task automatic bitIo(input logic b, output logic s);
    #750 sdaLow = !b;
    #750 scl = 1'b1;
    #500 s = sdaWire;
    #500 scl = 1'b0;
  endtask
  task automatic byteIo(input logic [7:0] d, input logic ackOut,
                        output logic [7:0] q, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bitIo(d[i], s);
      q[i] = s;
    end
    bitIo(!ackOut, s);
    ack = !s;
  endtask
endmodule

// ---- verilog/array_port.sv ----
// Programming cycle: copies a committed page into the array, then stays busy.
// Assumes the page words in the hand-over stay stable until done toggles.
`timescale 1ns/1ps
module array_port #(
  parameter int WRITE_CYCLES = eeprom_wr_pkg::WR_CYCLES
) (
  // Clock and control
  input  wire logic                             clk,
  input  wire logic                             rst,
  input  wire logic                             ce,
  // Page hand-over
  page_xfer_if.array                            xfer,
  // Array write port
  output logic                                  memWrEn,
  output logic [eeprom_wr_pkg::ADDR_W-1:0]      memWrAddr,
  output logic [eeprom_wr_pkg::BYTE_W-1:0]      memWrData
);
  import eeprom_wr_pkg::*;

  localparam int TMR_W     = $clog2(WRITE_CYCLES + 1);
  localparam int LAST_TICK = WRITE_CYCLES - CROSS_SLACK - 1;

  typedef enum logic [1:0] {P_IDLE, P_COPY, P_WAIT} prog_e;

  typedef struct packed {
    prog_e                 ph;
    logic                  lastReq;
    logic                  doneTgl;
    logic                  busy;
    logic [PAGE_IDX_W-1:0] idx;
    logic [TMR_W-1:0]      timer;
    logic                  wrEn;
    logic [ADDR_W-1:0]     wrAddr;
    logic [BYTE_W-1:0]     wrData;
  } prog_s;

  prog_s st;
  prog_s next_st;
  logic  reqS;

  sync2 #(.W(1)) reqSync (
    .clk (clk),
    .d   (xfer.commitTgl),
    .q   (reqS)
  );

  // ----------------------------------------------------------------------
  // Copy and timing
  // ----------------------------------------------------------------------
  always_comb begin
    next_st = st;
    if (rst) begin
      next_st    = '0;
      next_st.ph = P_IDLE;
    end else if (ce) begin
      next_st.wrEn = 1'b0;
      case (st.ph)
        P_IDLE: begin
          if (reqS != st.lastReq) begin
            next_st.lastReq = reqS;
            next_st.ph      = P_COPY;
            next_st.idx     = '0;
            next_st.timer   = '0;
            next_st.busy    = 1'b1;
          end
        end
        P_COPY: begin
          // Whole page goes in 16 cycles, one slot each; slots never written stay untouched
          next_st.timer  = st.timer + 1'b1;
          next_st.wrEn   = xfer.pageValid[st.idx];
          next_st.wrAddr = {xfer.pageTag, st.idx};
          next_st.wrData = xfer.pageData[st.idx];
          next_st.idx    = st.idx + 1'b1;
          if (st.idx == PAGE_IDX_W'(PAGE_BYTES - 1)) begin
            next_st.ph = P_WAIT;
          end
        end
        P_WAIT: begin
          next_st.timer = st.timer + 1'b1;
          if (st.timer == TMR_W'(LAST_TICK)) begin
            next_st.ph      = P_IDLE;
            next_st.busy    = 1'b0;
            next_st.doneTgl = ~st.doneTgl;
          end
        end
        default: next_st.ph = P_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    st <= next_st;
  end

  assign xfer.doneTgl = st.doneTgl;
  assign xfer.busy    = st.busy;
  assign memWrEn      = st.wrEn;
  assign memWrAddr    = st.wrAddr;
  assign memWrData    = st.wrData;
endmodule

// ---- verilog/eeprom_wr_pkg.sv ----
// Shared constants of the serial EEPROM write port: timing, widths, codes.
// Assumes a 25 MHz system clock; the link clock rate is not used here.
package eeprom_wr_pkg;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_HZ      = 25_000_000;
  localparam int T_WR_MS     = 10;
  // Longest time, so the division rounds down
  localparam int WR_CYCLES   = T_WR_MS * (CLK_HZ / 1000);
  // Margin for the two toggle crossings around the programming cycle
  localparam int CROSS_SLACK = 32;

  // ----------------------------------------------------------------------
  // Widths and layout
  // ----------------------------------------------------------------------
  localparam int ADDR_W      = 11;
  localparam int PAGE_IDX_W  = 4;
  localparam int PAGE_BYTES  = 16;
  localparam int BYTE_W      = 8;
  localparam int TAG_W       = ADDR_W - PAGE_IDX_W;

  // ----------------------------------------------------------------------
  // Codes and reset values
  // ----------------------------------------------------------------------
  localparam logic [3:0] DEV_TYPE      = 4'hA;
  localparam logic [3:0] BYTE_BITS     = 4'h8;
  localparam logic [3:0] LAST_TX_BIT   = 4'h7;
  localparam logic       DIR_READ      = 1'h1;
  localparam logic       OE_RELEASED   = 1'h1;

endpackage

// ---- verilog/i2c_eeprom_slave_write_port.sv ----
// Two-wire target port of a 16 Kbit EEPROM: start/stop, addressing, acknowledge,
// 16-byte page buffer, programming hand-over, busy polling and write protect.
// Assumes a free-running link clock far above SCL, SDA resolved outside as
// open drain, and the array with its read address counter beyond the ports.
`timescale 1ns/1ps
module i2c_eeprom_slave_write_port #(
  parameter int WRITE_CYCLES = eeprom_wr_pkg::WR_CYCLES
) (
  // System clock domain
  input  wire logic                               clk,
  input  wire logic                               rst,
  input  wire logic                               ce,
  // Link sampling clock
  input  wire logic                               linkClk,
  // Serial bus pins
  input  wire logic                               sclIn,
  input  wire logic                               sdaIn,
  output logic                                    sdaOut,
  output logic                                    sdaOeN,
  // Protection and supervisor status
  input  wire logic                               wp,
  input  wire logic                               resetActive,
  // Array write port
  output logic                                    memWrEn,
  output logic [eeprom_wr_pkg::ADDR_W-1:0]        memWrAddr,
  output logic [eeprom_wr_pkg::BYTE_W-1:0]        memWrData,
  // Array read port
  output logic                                    rdStrobe,
  input  wire logic [eeprom_wr_pkg::BYTE_W-1:0]   rdData,
  // Status
  output logic                                    busy
);
  import eeprom_wr_pkg::*;

  // ----------------------------------------------------------------------
  // Types and state
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    L_IDLE,
    L_ADDR,
    L_ADDR_ACK,
    L_WORD,
    L_WORD_ACK,
    L_DATA,
    L_DATA_ACK,
    L_RD_BIT,
    L_RD_ACK
  } link_e;

  typedef struct packed {
    link_e                             ph;
    logic                              prevScl;
    logic                              prevSda;
    logic [3:0]                        bitCnt;
    logic [BYTE_W-1:0]                 shift;
    logic                              rnw;
    logic                              masterAck;
    logic [ADDR_W-1:0]                 addr;
    logic [PAGE_BYTES-1:0][BYTE_W-1:0] pageData;
    logic [PAGE_BYTES-1:0]             pageValid;
    logic                              commitTgl;
    logic                              pending;
    logic                              lastDone;
    logic                              rdReqTgl;
    logic                              oeN;
  } link_s;

  typedef struct packed {
    logic              lastRd;
    logic              rdPend;
    logic              strobe;
    logic [BYTE_W-1:0] rdByte;
  } rd_s;

  link_s lk;
  link_s next_lk;
  rd_s   rs;
  rd_s   next_rs;

  logic [6:0] linkIn;
  logic       sclS;
  logic       sdaS;
  logic       wpS;
  logic       rstActS;
  logic       doneS;
  logic       linkRst;
  logic       linkCe;
  logic       rdReqS;
  logic       sclRise;
  logic       sclFall;
  logic       startDet;
  logic       stopDet;
  logic       devBusy;

  page_xfer_if xfer ();

  // ----------------------------------------------------------------------
  // Crossings into the link domain
  // ----------------------------------------------------------------------
  // Reset and enable are re-timed too, so the link state never sees a raw
  // system-clock level.
  sync2 #(.W(7)) linkSync (
    .clk (linkClk),
    .d   ({sclIn, sdaIn, wp, resetActive, xfer.doneTgl, rst, ce}),
    .q   (linkIn)
  );

  assign {sclS, sdaS, wpS, rstActS, doneS, linkRst, linkCe} = linkIn;

  // ----------------------------------------------------------------------
  // Bus conditions
  // ----------------------------------------------------------------------
  assign sclRise  = sclS & ~lk.prevScl;
  assign sclFall  = ~sclS & lk.prevScl;
  assign startDet = sclS & lk.prevScl & lk.prevSda & ~sdaS;
  assign stopDet  = sclS & lk.prevScl & ~lk.prevSda & sdaS;
  // Busy from the moment of the stop, not only once the crossing lands
  assign devBusy  = lk.pending;

  // ----------------------------------------------------------------------
  // Link protocol engine
  // ----------------------------------------------------------------------
  always_comb begin
    next_lk = lk;
    if (linkRst) begin
      next_lk     = '0;
      next_lk.ph  = L_IDLE;
      next_lk.oeN = OE_RELEASED;
    end else if (linkCe) begin
      next_lk.prevScl = sclS;
      next_lk.prevSda = sdaS;
      if (doneS != lk.lastDone) begin
        next_lk.lastDone = doneS;
        next_lk.pending  = 1'b0;
      end
      if (rstActS) begin
        next_lk.ph  = L_IDLE;
        next_lk.oeN = OE_RELEASED;
      end else if (stopDet) begin
        // A write only counts once stop arrives after whole data bytes
        if (lk.ph == L_DATA && |lk.pageValid && !lk.pending) begin
          next_lk.pending   = 1'b1;
          next_lk.commitTgl = ~lk.commitTgl;
        end
        next_lk.ph  = L_IDLE;
        next_lk.oeN = OE_RELEASED;
      end else if (startDet) begin
        next_lk.ph     = L_ADDR;
        next_lk.bitCnt = '0;
        next_lk.oeN    = OE_RELEASED;
      end else begin
        case (lk.ph)
          L_IDLE: begin
            next_lk.oeN = OE_RELEASED;
          end
          L_ADDR, L_WORD, L_DATA: begin
            if (sclRise) begin
              // Data is taken only at the rising edge, so it is settled
              next_lk.shift  = {lk.shift[BYTE_W-2:0], sdaS};
              next_lk.bitCnt = lk.bitCnt + 4'h1;
            end else if (sclFall && lk.bitCnt == BYTE_BITS) begin
              next_lk.bitCnt = '0;
              if (lk.ph == L_ADDR) begin
                if (lk.shift[7:4] == DEV_TYPE && !devBusy) begin
                  next_lk.oeN        = 1'b0;
                  next_lk.addr[10:8] = lk.shift[3:1];
                  next_lk.rnw        = (lk.shift[0] == DIR_READ);
                  next_lk.pageValid  = '0;
                  next_lk.ph         = L_ADDR_ACK;
                  if (lk.shift[0] == DIR_READ) begin
                    next_lk.rdReqTgl = ~lk.rdReqTgl;
                  end
                end else begin
                  next_lk.ph = L_IDLE;
                end
              end else if (lk.ph == L_WORD) begin
                next_lk.addr[7:0] = lk.shift;
                next_lk.oeN       = 1'b0;
                next_lk.ph        = L_WORD_ACK;
              end else if (wpS) begin
                // Protected: drop the page so stop finds nothing to program
                next_lk.pageValid = '0;
                next_lk.ph        = L_IDLE;
              end else begin
                next_lk.pageData[lk.addr[3:0]]  = lk.shift;
                next_lk.pageValid[lk.addr[3:0]] = 1'b1;
                next_lk.addr[3:0] = lk.addr[3:0] + 4'h1;
                next_lk.oeN       = 1'b0;
                next_lk.ph        = L_DATA_ACK;
              end
            end
          end
          L_ADDR_ACK: begin
            if (sclFall) begin
              if (lk.rnw) begin
                // First byte was requested at the match, one bit (the acknowledge) ago
                next_lk.shift    = rs.rdByte;
                next_lk.oeN      = rs.rdByte[BYTE_W-1];
                next_lk.rdReqTgl = ~lk.rdReqTgl;
                next_lk.ph       = L_RD_BIT;
              end else begin
                next_lk.oeN = OE_RELEASED;
                next_lk.ph  = L_WORD;
              end
            end
          end
          L_WORD_ACK, L_DATA_ACK: begin
            if (sclFall) begin
              next_lk.oeN = OE_RELEASED;
              next_lk.ph  = L_DATA;
            end
          end
          L_RD_BIT: begin
            if (sclFall) begin
              if (lk.bitCnt == LAST_TX_BIT) begin
                next_lk.oeN    = OE_RELEASED;
                next_lk.bitCnt = '0;
                next_lk.ph     = L_RD_ACK;
              end else begin
                next_lk.shift  = {lk.shift[BYTE_W-2:0], 1'b0};
                next_lk.oeN    = lk.shift[BYTE_W-2];
                next_lk.bitCnt = lk.bitCnt + 4'h1;
              end
            end
          end
          L_RD_ACK: begin
            if (sclRise) begin
              next_lk.masterAck = ~sdaS;
            end else if (sclFall) begin
              if (lk.masterAck) begin
                next_lk.shift    = rs.rdByte;
                next_lk.oeN      = rs.rdByte[BYTE_W-1];
                next_lk.rdReqTgl = ~lk.rdReqTgl;
                next_lk.ph       = L_RD_BIT;
              end else begin
                next_lk.ph = L_IDLE;
              end
            end
          end
          default: begin
            next_lk.ph  = L_IDLE;
            next_lk.oeN = OE_RELEASED;
          end
        endcase
      end
    end
  end

  always_ff @(posedge linkClk) begin
    lk <= next_lk;
  end

  // ----------------------------------------------------------------------
  // Read prefetch in the system domain
  // ----------------------------------------------------------------------
  // One byte is fetched ahead; a byte the master refuses is still fetched,
  // so the outside address counter runs one ahead after a read ends.
  sync2 #(.W(1)) rdSync (
    .clk (clk),
    .d   (lk.rdReqTgl),
    .q   (rdReqS)
  );

  always_comb begin
    next_rs = rs;
    if (rst) begin
      next_rs = '0;
    end else if (ce) begin
      next_rs.strobe = 1'b0;
      if (rdReqS != rs.lastRd) begin
        next_rs.lastRd = rdReqS;
        next_rs.strobe = 1'b1;
        next_rs.rdPend = 1'b1;
      end else if (rs.rdPend) begin
        next_rs.rdByte = rdData;
        next_rs.rdPend = 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    rs <= next_rs;
  end

  // ----------------------------------------------------------------------
  // Programming cycle
  // ----------------------------------------------------------------------
  assign xfer.commitTgl = lk.commitTgl;
  assign xfer.pageTag   = lk.addr[ADDR_W-1:PAGE_IDX_W];
  assign xfer.pageData  = lk.pageData;
  assign xfer.pageValid = lk.pageValid;

  array_port #(.WRITE_CYCLES(WRITE_CYCLES)) progCycle (
    .clk       (clk),
    .rst       (rst),
    .ce        (ce),
    .xfer      (xfer.array),
    .memWrEn   (memWrEn),
    .memWrAddr (memWrAddr),
    .memWrData (memWrData)
  );

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  // Open drain: the data level is always low, only the enable moves
  assign sdaOut   = 1'b0;
  assign sdaOeN   = lk.oeN;
  assign rdStrobe = rs.strobe;
  assign busy     = xfer.busy;
endmodule

// ---- verilog/page_xfer_if.sv ----
// Hand-over of a received page from the link logic to the programming logic.
// Assumes the link side keeps every word stable while busy is reported.
`timescale 1ns/1ps
interface page_xfer_if;
  import eeprom_wr_pkg::*;

  logic                                commitTgl;
  logic                                doneTgl;
  logic                                busy;
  logic [TAG_W-1:0]                    pageTag;
  logic [PAGE_BYTES-1:0][BYTE_W-1:0]   pageData;
  logic [PAGE_BYTES-1:0]               pageValid;

  modport link (
    output commitTgl, pageTag, pageData, pageValid,
    input  doneTgl, busy
  );

  modport array (
    input  commitTgl, pageTag, pageData, pageValid,
    output doneTgl, busy
  );

endinterface

// ---- verilog/sync2.sv ----
// Two-stage synchroniser for levels and toggles of any width.
// Assumes each bit is independent; words must be made stable by handshake.
`timescale 1ns/1ps
module sync2 #(
  parameter int W = 1
) (
  // Destination clock
  input  wire logic         clk,
  // Levels
  input  wire logic [W-1:0] d,
  output logic [W-1:0]      q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_s;

  sync_s st;
  sync_s next_st;

  // No reset and no enable: the stages must keep following the source
  always_comb begin
    next_st.s1 = d;
    next_st.s2 = st.s1;
  end

  always_ff @(posedge clk) begin
    st <= next_st;
  end

  assign q = st.s2;
endmodule
